// ===== design/debug_serial_unit.sv
// debug serial unit: apb registers, serial line, test modes,
// dma request hooks, debug channel flags, chip identity, tap reset
// assumes apb master on clk; dma engine sits outside and is reached
// through the dma area decode; serial input is asynchronous
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module debug_serial_unit
    import debug_serial_unit_pkg::*;
#(
    parameter logic [31:0] chip_id_value = 32'h8123_4560, // arbitrary
    parameter logic [31:0] chip_extension_value = 32'h0000_0001 // arbitrary
) (
    input  wire logic        clk,           // 20 MHz clock
    input  wire logic        resetn,        // async reset, low
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb access phase
    input  wire logic        pwrite,        // apb write
    input  wire logic [11:0] paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error, never set
    input  wire logic        serial_input_pin,  // async line in
    output logic             serial_output_pin, // line out
    output logic             rx_dma_request,    // receive dma request
    output logic             tx_dma_request,    // transmit dma request
    output logic             dma_area_sel,      // dma register strobe
    input  wire logic [31:0] dma_area_rdata,    // dma register data
    input  wire logic [3:0]  dma_status,        // endrx,endtx,txbufe,rxbuff
    input  wire logic        debug_channel_read_pending,  // from cpu
    input  wire logic        debug_channel_write_pending, // from cpu
    output logic             tap_reset_n        // tap reset, low
);
    // ************************************************************
    // registers and state
    // ************************************************************
    logic [31:0]      mode_config;
    logic [31:0]      interrupt_mask;
    logic [15:0]      baud_divisor;
    logic             test_reset_force;
    logic [2:0]       rx_pin_sync;
    logic             rx_pin;
    logic [15:0]      baud_count;
    logic             tick16;
    logic [3:0]       tx_phase;
    logic             tx_enabled, tx_off_pending;
    logic             tx_hold_full, tx_busy;
    logic [7:0]       tx_hold;
    logic [10:0]      tx_shift;
    logic [3:0]       tx_left;
    logic             tx_line;
    logic             rx_enabled, rx_off_pending;
    rx_state_type     rx_state;
    logic [3:0]       rx_phase, rx_count;
    logic [8:0]       rx_shift;
    logic [7:0]       receive_holding;
    logic             receive_ready_flag;
    logic             parity_error_flag, framing_error_flag;
    logic             overrun_error_flag;
    logic             transmit_ready_flag, transmitter_idle_flag;
    channel_mode_type chan;
    logic [2:0]       parity_select_field;
    logic             wr, rd, rx_in, rx_done;
    logic [31:0]      line_status, next_rdata;
    logic [3:0]       frame_len;

    // expected parity bit for a character, for both directions
    function automatic logic parity_of(input logic [7:0] d,
                                       input logic [2:0] p);
        unique case (p[1:0])
            2'b00:   parity_of = ^d;   // even
            2'b01:   parity_of = ~^d;  // odd
            2'b10:   parity_of = 1'b0; // space
            default: parity_of = 1'b1; // mark
        endcase
    endfunction : parity_of

    // zero-wait slave: every access completes in its access phase
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign chan    = channel_mode_type'(mode_config[channel_mode_lsb +: 2]);
    assign parity_select_field = mode_config[parity_select_lsb +: 3];
    assign frame_len = parity_select_field[2] ? 4'hA : 4'hB;

    // ************************************************************
    // configuration registers
    // ************************************************************
    // reserved mode bits are never stored, so they read back zero
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            mode_config <= mode_config_rst;
        else if (wr && paddr == mode_config_off)
            mode_config <= pwdata & 32'h0000_CE00;
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            baud_divisor <= baud_divisor_rst;
        else if (wr && paddr == baud_divisor_off)
            baud_divisor <= pwdata[15:0];
    // mask is kept for software; no interrupt line leaves this block
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            interrupt_mask <= interrupt_mask_rst;
        else if (wr && paddr == interrupt_enable_off)
            interrupt_mask <= interrupt_mask | (pwdata & status_used_mask);
        else if (wr && paddr == interrupt_disable_off)
            interrupt_mask <= interrupt_mask & ~pwdata;
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            test_reset_force <= test_reset_force_rst;
        else if (wr && paddr == test_reset_force_off)
            test_reset_force <= pwdata[0];
    assign tap_reset_n = ~test_reset_force;

    // ************************************************************
    // line input and baud timing
    // ************************************************************
    // three stages; a level counts once stages two and three agree
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
        begin
            rx_pin_sync <= 3'b111;
            rx_pin      <= 1'b1;
        end
        else
        begin
            rx_pin_sync <= {rx_pin_sync[1:0], serial_input_pin};
            if (rx_pin_sync[1] == rx_pin_sync[2])
                rx_pin <= rx_pin_sync[2];
        end
    // sixteen ticks per bit; a zero divisor stops the line logic
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
        begin
            baud_count <= 16'h0000;
            tick16     <= 1'b0;
        end
        else if (baud_divisor == 16'h0000)
        begin
            baud_count <= 16'h0000;
            tick16     <= 1'b0;
        end
        else
        begin
            tick16     <= (baud_count >= baud_divisor - 16'h0001);
            baud_count <= (baud_count >= baud_divisor - 16'h0001)
                          ? 16'h0000 : baud_count + 16'h0001;
        end

    // ************************************************************
    // transmitter
    // ************************************************************
    // enable/disable commands; disable waits for queued characters
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
        begin
            tx_enabled     <= 1'b0;
            tx_off_pending <= 1'b0;
        end
        else if (wr && paddr == control_command_off
                 && pwdata[transmitter_reset_cmd_pos])
        begin
            tx_enabled     <= 1'b0;
            tx_off_pending <= 1'b0;
        end
        else if (wr && paddr == control_command_off
                 && pwdata[transmitter_off_cmd_pos])
            tx_off_pending <= 1'b1;
        else if (wr && paddr == control_command_off
                 && pwdata[transmitter_on_cmd_pos])
        begin
            tx_enabled     <= 1'b1;
            tx_off_pending <= 1'b0;
        end
        else if (tx_off_pending && !tx_busy && !tx_hold_full)
        begin
            tx_enabled     <= 1'b0;
            tx_off_pending <= 1'b0;
        end
    // holding register, filled by software or the transmit dma
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
        begin
            tx_hold      <= 8'h00;
            tx_hold_full <= 1'b0;
        end
        else if (wr && paddr == control_command_off
                 && pwdata[transmitter_reset_cmd_pos])
            tx_hold_full <= 1'b0;
        else if (wr && paddr == transmit_holding_off && tx_enabled)
        begin
            tx_hold      <= pwdata[7:0];
            tx_hold_full <= 1'b1;
        end
        else if (tx_hold_full && !tx_busy && chan != mode_remote)
            tx_hold_full <= 1'b0;
    // shifter: start, eight data bits lsb first, parity when selected, stop
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
        begin
            tx_busy  <= 1'b0;
            tx_shift <= 11'h7FF;
            tx_left  <= 4'h0;
            tx_phase <= 4'h0;
            tx_line  <= 1'b1;
        end
        else if (wr && paddr == control_command_off
                 && pwdata[transmitter_reset_cmd_pos])
        begin
            tx_busy <= 1'b0;
            tx_line <= 1'b1;
        end
        else if (!tx_busy)
        begin
            tx_line <= 1'b1;
            if (tx_hold_full && chan != mode_remote)
            begin
                tx_busy  <= 1'b1;
                tx_left  <= frame_len;
                tx_phase <= 4'h0;
                tx_shift <= parity_select_field[2]
                    ? {2'b11, tx_hold, 1'b0}
                    : {1'b1, parity_of(tx_hold, parity_select_field), tx_hold, 1'b0};
            end
        end
        else if (tick16)
        begin
            tx_phase <= tx_phase + 4'h1;
            if (tx_phase == 4'h0)
            begin
                tx_line  <= tx_shift[0];
                tx_shift <= {1'b1, tx_shift[10:1]};
                tx_left  <= tx_left - 4'h1;
            end
            else if (tx_phase == 4'hF && tx_left == 4'h0)
                tx_busy <= 1'b0;
        end
    assign transmit_ready_flag   = tx_enabled & ~tx_hold_full;
    assign transmitter_idle_flag = transmit_ready_flag & ~tx_busy;
    assign tx_dma_request = transmit_ready_flag;

    // ************************************************************
    // channel mode steering
    // ************************************************************
    // the output pin is registered so mode changes do not glitch it
    always_comb
        unique case (chan)
            mode_local: rx_in = tx_line;
            mode_remote: rx_in = 1'b1;
            default: rx_in = rx_pin;
        endcase
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            serial_output_pin <= 1'b1;
        else
            unique case (chan)
                mode_normal: serial_output_pin <= tx_line;
                mode_echo: serial_output_pin <= rx_pin;
                mode_local: serial_output_pin <= 1'b1;
                mode_remote: serial_output_pin <= rx_pin;
            endcase

    // ************************************************************
    // receiver
    // ************************************************************
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
        begin
            rx_enabled     <= 1'b0;
            rx_off_pending <= 1'b0;
        end
        else if (wr && paddr == control_command_off
                 && pwdata[receiver_reset_cmd_pos])
        begin
            rx_enabled     <= 1'b0;
            rx_off_pending <= 1'b0;
        end
        else if (wr && paddr == control_command_off
                 && pwdata[receiver_off_cmd_pos])
        begin
            rx_enabled     <= rx_state != rx_idle;
            rx_off_pending <= rx_state != rx_idle;
        end
        else if (wr && paddr == control_command_off
                 && pwdata[receiver_on_cmd_pos])
        begin
            rx_enabled     <= 1'b1;
            rx_off_pending <= 1'b0;
        end
        else if (rx_off_pending && rx_state == rx_idle)
        begin
            rx_enabled     <= 1'b0;
            rx_off_pending <= 1'b0;
        end
    // start needs more than eight low samples; bits taken early in each cell, nine ticks after the start is confirmed
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
        begin
            rx_state <= rx_idle;
            rx_phase <= 4'h0;
            rx_count <= 4'h0;
            rx_shift <= 9'h000;
            rx_done  <= 1'b0;
        end
        else if (!rx_enabled || (wr && paddr == control_command_off
                 && pwdata[receiver_reset_cmd_pos]))
        begin
            rx_state <= rx_idle;
            rx_done  <= 1'b0;
        end
        else
        begin
            rx_done <= 1'b0;
            if (tick16)
                unique case (rx_state)
                    rx_idle:
                    begin
                        rx_phase <= 4'h0;
                        if (!rx_in && !rx_off_pending)
                            rx_state <= rx_start;
                    end
                    rx_start:
                        if (rx_in)
                            rx_state <= rx_idle;
                        else if (rx_phase == start_low_samples)
                        begin
                            rx_state <= rx_bits;
                            rx_phase <= half_bit_samples;
                            rx_count <= frame_len - 4'h2;
                        end
                        else
                            rx_phase <= rx_phase + 4'h1;
                    rx_bits:
                    begin
                        rx_phase <= rx_phase + 4'h1;
                        if (rx_phase == 4'h0 && rx_count == 4'h0)
                        begin
                            rx_state <= rx_idle;
                            rx_done  <= 1'b1;
                            // the stop sample is never stored: with parity the
                            // word already sits in 8:0, without it data moves down
                            if (parity_select_field[2])
                                rx_shift <= {1'b0, rx_shift[8:1]};
                        end
                        else if (rx_phase == 4'h0)
                        begin
                            rx_count <= rx_count - 4'h1;
                            rx_shift <= {rx_in, rx_shift[8:1]};
                        end
                    end
                    default: rx_state <= rx_idle;
                endcase
        end
    // character landing and sticky errors; an error wins over a clear
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
        begin
            receive_holding    <= 8'h00;
            receive_ready_flag <= 1'b0;
            parity_error_flag  <= 1'b0;
            framing_error_flag <= 1'b0;
            overrun_error_flag <= 1'b0;
        end
        else
        begin
            if (wr && paddr == control_command_off
                && pwdata[clear_error_flags_cmd_pos])
            begin
                parity_error_flag  <= 1'b0;
                framing_error_flag <= 1'b0;
                overrun_error_flag <= 1'b0;
            end
            if (rd && paddr == receive_holding_off)
                receive_ready_flag <= 1'b0;
            if (rx_done)
            begin
                receive_holding    <= rx_shift[7:0];
                receive_ready_flag <= 1'b1;
                if (receive_ready_flag)
                    overrun_error_flag <= 1'b1;
                if (!rx_in)
                    framing_error_flag <= 1'b1;
                if (!parity_select_field[2] && rx_shift[8]
                    != parity_of(rx_shift[7:0], parity_select_field))
                    parity_error_flag <= 1'b1;
            end
        end
    assign rx_dma_request = receive_ready_flag;

    // ************************************************************
    // status and read path
    // ************************************************************
    assign line_status = {debug_channel_read_pending,
                          debug_channel_write_pending, 17'h0,
                          dma_status[0], dma_status[1], 1'b0,
                          transmitter_idle_flag, 1'b0,
                          parity_error_flag, framing_error_flag,
                          overrun_error_flag, dma_status[2],
                          dma_status[3], 1'b0,
                          transmit_ready_flag, receive_ready_flag};
    assign dma_area_sel = psel && paddr >= dma_area_first
                          && paddr <= dma_area_last;
    // unlisted offsets read zero and swallow writes
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (dma_area_sel)
            next_rdata = dma_area_rdata;
        else
            unique case (paddr)
                mode_config_off: next_rdata = mode_config;
                interrupt_mask_off: next_rdata = interrupt_mask;
                line_status_off: next_rdata = line_status;
                receive_holding_off: next_rdata = {24'h0, receive_holding};
                baud_divisor_off: next_rdata = {16'h0, baud_divisor};
                chip_identity_off: next_rdata = chip_id_value;
                chip_identity_extension_off: next_rdata =
                    chip_id_value[extension_present_pos]
                    ? chip_extension_value : 32'h0000_0000;
                test_reset_force_off: next_rdata = {31'h0, test_reset_force};
                default: next_rdata = 32'h0000_0000;
            endcase
    end
    assign prdata = rd ? next_rdata : 32'h0000_0000;
endmodule : debug_serial_unit
`default_nettype wire

// ===== design/debug_serial_unit_pkg.sv
// constants shared by the debug serial unit control logic
// assumes a 32-bit apb register bus and one 20 MHz clock
package debug_serial_unit_pkg;
    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [11:0] control_command_off   = 12'h000;
    localparam logic [11:0] mode_config_off       = 12'h004;
    localparam logic [11:0] interrupt_enable_off  = 12'h008;
    localparam logic [11:0] interrupt_disable_off = 12'h00C;
    localparam logic [11:0] interrupt_mask_off    = 12'h010;
    localparam logic [11:0] line_status_off       = 12'h014;
    localparam logic [11:0] receive_holding_off   = 12'h018;
    localparam logic [11:0] transmit_holding_off  = 12'h01C;
    localparam logic [11:0] baud_divisor_off      = 12'h020;
    localparam logic [11:0] chip_identity_off     = 12'h040;
    localparam logic [11:0] chip_identity_extension_off = 12'h044;
    localparam logic [11:0] test_reset_force_off  = 12'h048;
    localparam logic [11:0] dma_area_first        = 12'h100;
    localparam logic [11:0] dma_area_last         = 12'h124;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int receiver_reset_cmd_pos    = 2;
    localparam int transmitter_reset_cmd_pos = 3;
    localparam int receiver_on_cmd_pos       = 4;
    localparam int receiver_off_cmd_pos      = 5;
    localparam int transmitter_on_cmd_pos    = 6;
    localparam int transmitter_off_cmd_pos   = 7;
    localparam int clear_error_flags_cmd_pos = 8;
    localparam int parity_select_lsb         = 9;
    localparam int channel_mode_lsb          = 14;
    localparam int extension_present_pos     = 31;
    // ************************************************************
    // reset values and counts
    // ************************************************************
    localparam logic [31:0] mode_config_rst      = 32'h0000_0000;
    localparam logic [31:0] interrupt_mask_rst   = 32'h0000_0000;
    localparam logic [15:0] baud_divisor_rst     = 16'h0000;
    localparam logic        test_reset_force_rst = 1'b0;
    localparam logic [31:0] status_used_mask     = 32'hC000_1AFB;
    localparam logic [3:0]  start_low_samples    = 4'h7;
    localparam logic [3:0]  half_bit_samples     = 4'h8;
    localparam logic [3:0]  data_bits            = 4'h8;

    typedef enum logic [1:0] {
        mode_normal   = 2'b00,
        mode_echo     = 2'b01,
        mode_local    = 2'b10,
        mode_remote   = 2'b11
    } channel_mode_type;

    typedef enum logic [1:0] {
        rx_idle  = 2'b00,
        rx_start = 2'b01,
        rx_bits  = 2'b10
    } rx_state_type;
endpackage : debug_serial_unit_pkg

// ===== tb/debug_serial_unit_checker.sv
// checker: apb decode and tap reset relations
// assumes one clock; bound below
`timescale 1ns/1ps
`default_nettype none
module debug_serial_unit_checker (
    input wire logic        clk,            // clock
    input wire logic        resetn,         // reset
    input wire logic        psel,           // select
    input wire logic        penable,        // access
    input wire logic        pwrite,         // write
    input wire logic [11:0] paddr,          // address
    input wire logic [31:0] pwdata,         // wdata
    input wire logic [31:0] prdata,         // rdata
    input wire logic        rx_dma_request, // rx ready
    input wire logic        tx_dma_request, // tx ready
    input wire logic        dma_area_sel,   // dma strobe
    input wire logic        tap_reset_n     // tap reset
);
    // a force register write is the only cause that may move the tap reset
    wire logic rd = psel && penable && !pwrite;
    wire logic wf = psel && penable && pwrite && paddr == 12'h048;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_gap_zero: assert property (rd && paddr inside {12'h0, 12'h8, 12'hC, 12'h1C,
        [12'h24:12'h3C]} |-> prdata == 32'h0) else $error("gap read");
    a_dma_decode: assert property (
        dma_area_sel == (psel && paddr >= 12'h100 && paddr <= 12'h124)) else $error("dma sel");
    a_ready_bits: assert property (rd && paddr == 12'h14 |->
        prdata[1:0] == {tx_dma_request, rx_dma_request}) else $error("ready bits");
    a_tap_set: assert property (wf && pwdata[0] |=> !tap_reset_n) else $error("tap");
    a_tap_free: assert property (wf && !pwdata[0] |=> tap_reset_n) else $error("tap");
    a_tap_hold: assert property (!wf |=> $stable(tap_reset_n)) else $error("tap");
    a_force_read: assert property (rd && paddr == 12'h48 |->
        prdata == {31'h0, !tap_reset_n}) else $error("force read");
    a_mode_mask: assert property (rd && paddr == 12'h4 |->
        (prdata & 32'hFFFF_31FF) == 32'h0) else $error("mode bits");
endmodule : debug_serial_unit_checker
bind debug_serial_unit debug_serial_unit_checker chk_i (.clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .rx_dma_request, .tx_dma_request, .dma_area_sel, .tap_reset_n);
`default_nettype wire

// ===== tb/host_terminal.sv
// host terminal: idle-high serial line into the unit
// assumes divisor 1, sixteen clocks a bit
`timescale 1ns/1ps
`default_nettype none
module host_terminal (
    input  wire logic clk,  // unit clock
    output var  logic line  // line to the unit
);
    initial line = 1'h1;
    // plain level, for pin-follow modes
    task automatic level(input logic v);
        line <= v;
    endtask : level
    // start, 8 data lsb first, no parity, chosen stop level
    task automatic send(input logic [7:0] b, input logic stop);
        line <= 1'h0;
        repeat (16) @(posedge clk);
        for (int i = 0; i < 9; i++)
        begin
            line <= (i < 8) ? b[i] : stop;
            repeat (16) @(posedge clk);
        end
        line <= 1'h1;
    endtask : send
endmodule : host_terminal
`default_nettype wire

// ===== tb/debug_serial_unit_tb.sv
// bench: registers, tap reset, test modes, receive
// assumes the bound checker and host_terminal
`timescale 1ns/1ps
`default_nettype none
module debug_serial_unit_tb;
    logic clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, serial_input_pin, serial_output_pin, h;
    logic rx_dma_request, tx_dma_request, dma_area_sel, tap_reset_n;
    logic rp = 1'h1, wp = 1'h0;
    logic [3:0] ds = 4'hA;
    int fails = 0, total_checks = 0;
    host_terminal host (.clk, .line(serial_input_pin));
    // identity values arbitrary; extension bit clear
    debug_serial_unit #(.chip_id_value(32'h0123_4567),
        .chip_extension_value(32'h0000_0042)) uut (
        .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .serial_input_pin, .serial_output_pin, .rx_dma_request, .tx_dma_request, .dma_area_sel,
        .dma_area_rdata(32'h0BAD_F00D), .dma_status(ds), .debug_channel_read_pending(rp),
        .debug_channel_write_pending(wp), .tap_reset_n);
    initial forever #25 clk = ~clk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            fails++;
            $display("mismatch %0t saw %h want %h", $time, s, e);
        end
    endtask : chk
    // idle cycle after release, so psel never flips twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge clk) penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        q = prdata;
        {psel, penable} <= 2'h0;
        @(posedge clk);
    endtask : apb
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(q, e);
    endtask : rc
    task automatic end_sim;
        if (fails == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic t_regs;
        rc(12'h048, 32'h0);
        rc(12'h040, 32'h0123_4567);
        rc(12'h044, 32'h0);
        rc(12'h100, 32'h0BAD_F00D);
        rc(12'h014, 32'h8000_0808);
        {rp, wp, ds} <= {1'h0, 1'h1, 4'h5};
        rc(12'h014, 32'h4000_1010);
        apb(1'h1, 12'h030, 32'hFFFF_FFFF);
        rc(12'h030, 32'h0);
        apb(1'h1, 12'h004, 32'hFFFF_FFFF);
        rc(12'h004, 32'h0000_CE00);
        apb(1'h1, 12'h048, 32'h1);
        chk({31'h0, tap_reset_n}, 32'h0);
        apb(1'h1, 12'h048, 32'h0);
    endtask : t_regs
    // local loop: output must stay idle while the char comes back
    task automatic t_loop;
        h = 1'h1;
        apb(1'h1, 12'h020, 32'h1);
        apb(1'h1, 12'h004, 32'h8000);
        apb(1'h1, 12'h000, 32'h50);
        chk({31'h0, tx_dma_request}, 32'h1);
        apb(1'h1, 12'h01C, 32'hA5);
        repeat (600) if (rx_dma_request !== 1'h1) @(posedge clk) h &= serial_output_pin;
        chk({31'h0, h}, 32'h1);
        rc(12'h018, 32'hA5);
        chk({31'h0, rx_dma_request}, 32'h0);
    endtask : t_loop
    task automatic t_follow;
        for (int i = 1; i < 4; i += 2)
        begin
            apb(1'h1, 12'h004, 32'(i) << 14);
            host.level(1'h0);
            repeat (8) @(posedge clk);
            chk({31'h0, serial_output_pin}, 32'h0);
            host.level(1'h1);
            repeat (8) @(posedge clk);
        end
    endtask : t_follow
    // receiver reset mutes the line; framing error then clear
    task automatic t_rx;
        apb(1'h1, 12'h000, 32'h4);
        apb(1'h0, 12'h018, 32'h0);
        apb(1'h1, 12'h004, 32'h0800);
        host.send(8'h11, 1'h1);
        chk({31'h0, rx_dma_request}, 32'h0);
        apb(1'h1, 12'h000, 32'h10);
        host.send(8'h3C, 1'h0);
        apb(1'h0, 12'h014, 32'h0);
        chk(q & 32'h41, 32'h41);
        rc(12'h018, 32'h3C);
        apb(1'h1, 12'h000, 32'h100);
        apb(1'h0, 12'h014, 32'h0);
        chk(q & 32'hE0, 32'h0);
    endtask : t_rx
    initial
    begin
        repeat (6) @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        t_regs;
        t_loop;
        t_follow;
        t_rx;
        end_sim;
    end
    // watchdog, about thirty times the expected run
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim;
    end
endmodule : debug_serial_unit_tb
`default_nettype wire
